// >>> hw/adc_input_mux_control.sv
// adc_input_mux_control: special-function registers for the analog
// input multiplexer and the registered switch controls they produce.
// assumes a byte-wide register port synchronous to clk_in, with a
// page number that tells apart the two registers sharing one address.

`timescale 1ns/1ps
`default_nettype none

// How it works
// - pairing and channel bits 7-4 read zero and ignore writes.
// - pairing bit 3 makes the even pins plus and the odd pins minus.
// - pairing bit 2 pairs the amplifier output with its reference.
// - pairing bit 1 makes input 2 the plus side and input 3 the minus side.
// - pairing bit 0 makes input 0 the plus side and input 1 the minus side.
// - a differential selection flags the result as two's complement.
// - codes route inputs 0-3, amplifier, ground, even, odd; 1xxx the sensor.
// - with a pair bit set, both codes of that pair select the same pair.
// - each pin select bit connects its port pin as analog input; resets 0.
// - any number of pins may be on; evens join the even input, odds the odd.
// - after reset every input pair is single-ended.
module adc_input_mux_control
  import adc_mux_pkg::*;
#(
  parameter int PIN_COUNT = 8
)
(
  input  wire logic                  clk_in,
  input  wire logic                  reset_n_in,
  input  wire logic [7:0]            sfr_addr_in,
  input  wire logic [7:0]            sfr_page_in,
  input  wire logic [7:0]            sfr_wdata_in,
  input  wire logic                  sfr_wr_in,
  input  wire logic                  sfr_rd_in,
  output logic      [7:0]            sfr_rdata_out,
  output adc_mux_pkg::mux_src_t      pos_src_out,
  output adc_mux_pkg::mux_src_t      neg_src_out,
  output logic                       differential_out,
  output logic                       twos_complement_out,
  output logic      [PIN_COUNT-1:0]  pin_connect_out,
  output logic                       even_input_active_out,
  output logic                       odd_input_active_out
);

  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  // the pin select register is a single byte with even/odd pairs
  if (PIN_COUNT != 8)
  begin : g_bad_pin_count
    $error("adc_input_mux_control: PIN_COUNT must be 8");
  end

  // pin select shares its address with pairing, so pages must differ
  if (PAGE_MUX == PAGE_PIN_SELECT)
  begin : g_page_clash
    $error("adc_input_mux_control: shared-address pages clash");
  end

  // pairing and channel registers must sit at two addresses
  if (ADDR_PAIR_CFG == ADDR_CHAN_SEL)
  begin : g_addr_clash
    $error("adc_input_mux_control: register addresses clash");
  end

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [3:0]           pair_cfg_q;
  logic [3:0]           pair_cfg_d;
  logic [3:0]           chan_sel_q;
  logic [3:0]           chan_sel_d;
  logic [PIN_COUNT-1:0] pin_sel_q;
  logic [PIN_COUNT-1:0] pin_sel_d;
  logic [7:0]           rdata_d;
  mux_src_t             pos_src_d;
  mux_src_t             neg_src_d;
  logic                 diff_d;
  logic                 even_on_d;
  logic                 odd_on_d;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire logic page_mux;
  wire logic page_pins;
  wire logic hit_cfg;
  wire logic hit_pins;
  wire logic hit_chan;
  assign page_mux  = (sfr_page_in == PAGE_MUX);
  assign page_pins = (sfr_page_in == PAGE_PIN_SELECT);
  assign hit_cfg   = page_mux && (sfr_addr_in == ADDR_PAIR_CFG);
  assign hit_chan  = page_mux && (sfr_addr_in == ADDR_CHAN_SEL);
  assign hit_pins  = page_pins && (sfr_addr_in == ADDR_PIN_SELECT);

  // ---------------------------------------------------------------
  // write strobes and read words
  // ---------------------------------------------------------------
  // one strobe per register keeps the next-value muxes readable
  wire logic       wr_cfg;
  wire logic       wr_chan;
  wire logic       wr_pins;
  wire logic [7:0] cfg_word;
  wire logic [7:0] chan_word;
  wire logic [7:0] read_mux;
  assign wr_cfg  = sfr_wr_in && hit_cfg;
  assign wr_chan = sfr_wr_in && hit_chan;
  assign wr_pins = sfr_wr_in && hit_pins;
  // the unused top nibble is tied off here and never stored
  assign cfg_word  = {UNUSED_HIGH_NIBBLE, pair_cfg_q};
  assign chan_word = {UNUSED_HIGH_NIBBLE, chan_sel_q};

  // next register values; pairing and channel keep only the low nibble
  assign pair_cfg_d = wr_cfg  ? sfr_wdata_in[3:0] : pair_cfg_q;
  assign chan_sel_d = wr_chan ? sfr_wdata_in[3:0] : chan_sel_q;
  assign pin_sel_d  = wr_pins ? sfr_wdata_in[PIN_COUNT-1:0]
                              : pin_sel_q;

  // read mux; unmapped addresses read as zero
  assign read_mux = hit_cfg  ? cfg_word  :
                    hit_chan ? chan_word :
                    hit_pins ? pin_sel_q :
                               8'h00;
  // read data holds its word between read strobes
  assign rdata_d  = sfr_rd_in ? read_mux : sfr_rdata_out;

  // ---------------------------------------------------------------
  // switch decode on the next values
  // ---------------------------------------------------------------
  // decoding the _d values lets the flopped controls land together
  // with the register itself, one clock after the write strobe
  mux_switch_decode u_decode (
    .pair_cfg_in      (pair_cfg_d),
    .channel_code_in  (chan_sel_d),
    .pos_src_out      (pos_src_d),
    .neg_src_out      (neg_src_d),
    .differential_out (diff_d)
  );

  // even pins share one multiplexer input, odd pins the other
  logic [PIN_COUNT/2-1:0] even_bits;
  logic [PIN_COUNT/2-1:0] odd_bits;
  for (genvar i = 0; i < PIN_COUNT / 2; i++)
  begin : g_pin_pairs
    assign even_bits[i] = pin_sel_d[2 * i];
    assign odd_bits[i]  = pin_sel_d[2 * i + 1];
  end
  // wired-or: any enabled pin of a parity drives that input
  assign even_on_d = |even_bits;
  assign odd_on_d  = |odd_bits;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // one short process per register; each resets asynchronously and
  // loads its _d value on every clock, so none needs an enable

  // pairing bits; every input pair resets single-ended, which is
  // also the safe state before software picks a channel
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pair_cfg_q <= RST_PAIR_CFG;
    end
    else
    begin
      pair_cfg_q <= pair_cfg_d;
    end
  end

  // channel code
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      chan_sel_q <= RST_CHAN_SEL;
    end
    else
    begin
      chan_sel_q <= chan_sel_d;
    end
  end

  // pin select register; no pin is connected out of reset, so a
  // port pin stays digital until software asks for it
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pin_sel_q <= RST_PIN_SELECT;
    end
    else
    begin
      pin_sel_q <= pin_sel_d;
    end
  end

  // read data; rdata_d carries the old word between read strobes,
  // so the flop loads every clock like all the others
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      sfr_rdata_out <= 8'h00;
    end
    else
    begin
      sfr_rdata_out <= rdata_d;
    end
  end

  // positive switch; fed from the next-value decode so it moves on
  // the same edge as the register write
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pos_src_out <= SRC_EXT0;
    end
    else
    begin
      pos_src_out <= pos_src_d;
    end
  end

  // negative switch; ground while the channel is single-ended
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      neg_src_out <= SRC_AGND;
    end
    else
    begin
      neg_src_out <= neg_src_d;
    end
  end

  // pair indicator
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      differential_out <= 1'b0;
    end
    else
    begin
      differential_out <= diff_d;
    end
  end

  // result format; a pair always converts to two's complement, so
  // this is a second copy of the pair indicator
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      twos_complement_out <= 1'b0;
    end
    else
    begin
      twos_complement_out <= diff_d;
    end
  end

  // pin switches
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pin_connect_out <= RST_PIN_SELECT;
    end
    else
    begin
      pin_connect_out <= pin_sel_d;
    end
  end

  // any enabled even pin drives the shared even input
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      even_input_active_out <= 1'b0;
    end
    else
    begin
      even_input_active_out <= even_on_d;
    end
  end

  // any enabled odd pin drives the shared odd input
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      odd_input_active_out <= 1'b0;
    end
    else
    begin
      odd_input_active_out <= odd_on_d;
    end
  end

endmodule : adc_input_mux_control

`default_nettype wire

// >>> hw/adc_mux_pkg.sv
// adc_mux_pkg: register map, field layout and source codes for the
// analog input multiplexer control.
// assumes a byte-wide special-function register port with paging.

package adc_mux_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PAIR_CFG   = 8'hba; // shared with pin select
  localparam logic [7:0] ADDR_PIN_SELECT = 8'hba;
  localparam logic [7:0] ADDR_CHAN_SEL   = 8'hbb;
  localparam logic [7:0] PAGE_MUX        = 8'h00;
  localparam logic [7:0] PAGE_PIN_SELECT = 8'h0f;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int         BIT_INPUTS_0_1_DIFF = 0;
  localparam int         BIT_INPUTS_2_3_DIFF = 1;
  localparam int         BIT_AMP_DIFF        = 2;
  localparam int         BIT_PORT_PAIR_DIFF  = 3;
  localparam int         CODE_TEMP_BIT       = 3;
  localparam logic [3:0] RST_PAIR_CFG        = 4'h0;
  localparam logic [3:0] RST_CHAN_SEL        = 4'h0;
  localparam logic [7:0] RST_PIN_SELECT      = 8'h00;
  localparam logic [3:0] UNUSED_HIGH_NIBBLE  = 4'h0;

  // ---------------------------------------------------------------
  // multiplexer sources
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    SRC_EXT0     = 4'h0,
    SRC_EXT1     = 4'h1,
    SRC_EXT2     = 4'h2,
    SRC_EXT3     = 4'h3,
    SRC_AMP      = 4'h4,
    SRC_AGND     = 4'h5,
    SRC_EVEN     = 4'h6,
    SRC_ODD      = 4'h7,
    SRC_TEMP     = 4'h8,
    SRC_AMP_REF  = 4'h9
  } mux_src_t;

endpackage : adc_mux_pkg

// >>> hw/mux_switch_decode.sv
// mux_switch_decode: turns pairing bits and a channel code into the
// positive and negative switch selections of the analog multiplexer.
// assumes next-value inputs from the register block; purely combinational.

`timescale 1ns/1ps
`default_nettype none

module mux_switch_decode
  import adc_mux_pkg::*;
(
  input  wire logic [3:0]           pair_cfg_in,
  input  wire logic [3:0]           channel_code_in,
  output adc_mux_pkg::mux_src_t     pos_src_out,
  output adc_mux_pkg::mux_src_t     neg_src_out,
  output logic                      differential_out
);

  // ---------------------------------------------------------------
  // channel decode
  // ---------------------------------------------------------------
  wire logic pair_on;
  wire logic odd_code;
  assign odd_code = channel_code_in[0];
  // pick the pairing bit that covers this code pair
  assign pair_on  = pair_cfg_in[channel_code_in[2:1]];

  // single-ended sources take ground as the negative side
  always_comb
  begin
    pos_src_out      = SRC_TEMP;
    neg_src_out      = SRC_AGND;
    differential_out = 1'b0;
    if (channel_code_in[CODE_TEMP_BIT])
    begin
      pos_src_out = SRC_TEMP;
    end
    else if (pair_on)
    begin
      differential_out = 1'b1;
      case (channel_code_in[2:1])
        2'b00:
        begin
          pos_src_out = SRC_EXT0;
          neg_src_out = SRC_EXT1;
        end
        2'b01:
        begin
          pos_src_out = SRC_EXT2;
          neg_src_out = SRC_EXT3;
        end
        2'b10:
        begin
          pos_src_out = SRC_AMP;
          neg_src_out = SRC_AMP_REF;
        end
        default:
        begin
          pos_src_out = SRC_EVEN;
          neg_src_out = SRC_ODD;
        end
      endcase
    end
    else
    begin
      case (channel_code_in[2:1])
        2'b00:   pos_src_out = odd_code ? SRC_EXT1 : SRC_EXT0;
        2'b01:   pos_src_out = odd_code ? SRC_EXT3 : SRC_EXT2;
        2'b10:   pos_src_out = odd_code ? SRC_AGND : SRC_AMP;
        default: pos_src_out = odd_code ? SRC_ODD : SRC_EVEN;
      endcase
    end
  end

endmodule : mux_switch_decode

`default_nettype wire

// >>> testbench/adc_input_mux_control_assertions.sv
// checker for the mux control block's registers and switch outputs
// assumes binding to adc_input_mux_control, one clock domain
`timescale 1ns/1ps
`default_nettype none
module adc_input_mux_control_assertions
#(
  parameter int PIN_COUNT = 8
)
(
  input wire logic                  clk_in,
  input wire logic                  reset_n_in,
  input wire logic [7:0]            sfr_addr_in,
  input wire logic [7:0]            sfr_page_in,
  input wire logic [7:0]            sfr_wdata_in,
  input wire logic                  sfr_wr_in,
  input wire logic                  sfr_rd_in,
  input wire logic [7:0]            sfr_rdata_out,
  input wire adc_mux_pkg::mux_src_t pos_src_out,
  input wire adc_mux_pkg::mux_src_t neg_src_out,
  input wire logic                  differential_out,
  input wire logic                  twos_complement_out,
  input wire logic [PIN_COUNT-1:0]  pin_connect_out,
  input wire logic                  even_input_active_out,
  input wire logic                  odd_input_active_out
);
  import adc_mux_pkg::*;
  localparam logic [PIN_COUNT-1:0] EVENS = PIN_COUNT'({PIN_COUNT{2'b01}});
  // strobes decoded here so each property names its own cause
  wire logic chan_wr = sfr_wr_in && sfr_page_in == PAGE_MUX
    && sfr_addr_in == ADDR_CHAN_SEL;
  wire logic pin_wr = sfr_wr_in && sfr_page_in == PAGE_PIN_SELECT
    && sfr_addr_in == ADDR_PIN_SELECT;
  wire logic [PIN_COUNT-1:0] wpins = sfr_wdata_in[PIN_COUNT-1:0];
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  high_nibble_a: assert property (sfr_rd_in && sfr_page_in == PAGE_MUX
    |=> sfr_rdata_out[7:4] == 4'h0) else $error("high nibble set");
  pin_write_a: assert property (pin_wr
    |=> pin_connect_out == $past(wpins)) else $error("pins not updated");
  temp_code_a: assert property (chan_wr && sfr_wdata_in[3]
    |=> pos_src_out == SRC_TEMP && !differential_out) else $error("temp");
  twos_follow_a: assert property (twos_complement_out
    == differential_out) else $error("format differs");
  single_neg_a: assert property (!differential_out
    |-> neg_src_out == SRC_AGND) else $error("single neg side");
  amp_ref_a: assert property (differential_out
    && pos_src_out == SRC_AMP |-> neg_src_out == SRC_AMP_REF)
    else $error("amp pair");
  even_or_a: assert property (even_input_active_out
    == |(pin_connect_out & EVENS)) else $error("even flag");
  odd_or_a: assert property (odd_input_active_out
    == |(pin_connect_out & ~EVENS)) else $error("odd flag");
endmodule : adc_input_mux_control_assertions
bind adc_input_mux_control adc_input_mux_control_assertions
  #(.PIN_COUNT(PIN_COUNT)) checker_i (.clk_in, .reset_n_in, .sfr_addr_in,
  .sfr_page_in, .sfr_wdata_in, .sfr_wr_in, .sfr_rd_in, .sfr_rdata_out,
  .pos_src_out, .neg_src_out, .differential_out, .twos_complement_out,
  .pin_connect_out, .even_input_active_out, .odd_input_active_out);
`default_nettype wire

// >>> testbench/mux_switch_model.sv
// analog switch model: levels seen at the converter's two inputs
// assumes source codes of adc_mux_pkg; one logic level per port pin
`timescale 1ns/1ps
`default_nettype none
module mux_switch_model
(
  input  wire adc_mux_pkg::mux_src_t pos_src_in,
  input  wire adc_mux_pkg::mux_src_t neg_src_in,
  input  wire logic [7:0]            pin_connect_in,
  input  wire logic [7:0]            pin_level_in,
  output logic [7:0]                 pos_level_out,
  output logic [7:0]                 neg_level_out
);
  import adc_mux_pkg::*;
  // a pin not connected never reaches the shared lines
  wire logic [7:0] on_pins = pin_connect_in & pin_level_in;
  wire logic ev = |(on_pins & 8'h55); // wired-or of even pins
  wire logic od = |(on_pins & 8'haa);
  // other sources carry a fixed level tagged with their code
  function automatic logic [7:0] lvl(input mux_src_t s, input logic e, o);
    return s == SRC_EVEN ? {7'h0, e} : s == SRC_ODD ? {7'h0, o} : {4'ha, s};
  endfunction : lvl
  assign pos_level_out = lvl(pos_src_in, ev, od);
  assign neg_level_out = lvl(neg_src_in, ev, od);
endmodule : mux_switch_model
`default_nettype wire

// >>> testbench/test_adc_input_mux_control.sv
// testbench for the mux control block with the switch model attached
// assumes a 250 MHz clock and the register port of the design
`timescale 1ns/1ps
`default_nettype none
module test_adc_input_mux_control;
  import adc_mux_pkg::*;
  logic       clk_in = 1'b0;
  logic       reset_n_in = 1'b0;
  logic       sfr_wr_in = 1'b0;
  logic       sfr_rd_in = 1'b0;
  logic [7:0] sfr_addr_in = 8'h00;
  logic [7:0] sfr_page_in = 8'h00;
  logic [7:0] sfr_wdata_in = 8'h00;
  logic [7:0] levels = 8'h00;
  logic [7:0] sfr_rdata_out, pin_connect_out, pos_lvl, neg_lvl;
  mux_src_t   pos_src_out, neg_src_out;
  logic       differential_out, twos_complement_out;
  logic       even_input_active_out, odd_input_active_out;
  int         err_total = 0;
  int         compares = 0;
  always #2 clk_in = ~clk_in;
  adc_input_mux_control DUT (.clk_in, .reset_n_in, .sfr_addr_in,
    .sfr_page_in, .sfr_wdata_in, .sfr_wr_in, .sfr_rd_in, .sfr_rdata_out,
    .pos_src_out, .neg_src_out, .differential_out, .twos_complement_out,
    .pin_connect_out, .even_input_active_out, .odd_input_active_out);
  mux_switch_model model (.pos_src_in(pos_src_out), .neg_src_in(neg_src_out),
    .pin_connect_in(pin_connect_out), .pin_level_in(levels),
    .pos_level_out(pos_lvl), .neg_level_out(neg_lvl));
  task automatic chk(input string what, input logic [7:0] exp, got);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one strobe held over exactly one edge; results land just after it
  task automatic bus(input logic w, input logic [7:0] pg, ad, d);
    @(posedge clk_in);
    sfr_wr_in <= w;
    sfr_rd_in <= !w;
    sfr_page_in <= pg;
    sfr_addr_in <= ad;
    sfr_wdata_in <= d;
    @(posedge clk_in);
    sfr_wr_in <= 1'b0;
    sfr_rd_in <= 1'b0;
    #1;
  endtask : bus
  task automatic t_reset;
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    #1;
    chk("pos", SRC_EXT0, pos_src_out);
    chk("neg", SRC_AGND, neg_src_out);
    chk("pins", 8'h00, pin_connect_out);
    chk("flags", 8'h00, {4'h0, differential_out, twos_complement_out,
      even_input_active_out, odd_input_active_out});
    bus(1'b0, PAGE_MUX, ADDR_PAIR_CFG, 8'h00);
    chk("cfg", 8'h00, sfr_rdata_out);
  endtask : t_reset
  // every pairing setting against every channel code
  task automatic t_table;
    logic [3:0] cfg;
    logic [3:0] code;
    logic       paired;
    for (int c = 0; c < 16; c++)
    begin
      cfg = c[3:0];
      bus(1'b1, PAGE_MUX, ADDR_PAIR_CFG, {4'hf, cfg});
      bus(1'b0, PAGE_MUX, ADDR_PAIR_CFG, 8'h00);
      chk("cfg", {4'h0, cfg}, sfr_rdata_out);
      for (int k = 0; k < 16; k++)
      begin
        code = k[3:0];
        paired = !code[3] && cfg[code[2:1]];
        bus(1'b1, PAGE_MUX, ADDR_CHAN_SEL, {4'ha, code});
        chk("pos", code[3] ? SRC_TEMP : paired ? code & 4'he : code,
          pos_src_out);
        chk("neg", !paired ? SRC_AGND : code[2:1] == 2'd2 ? SRC_AMP_REF
          : code | 4'h1, neg_src_out);
        chk("diff", {7'h0, paired}, {7'h0, differential_out});
        chk("twos", {7'h0, paired}, {7'h0, twos_complement_out});
      end
    end
  endtask : t_table
  // pin patterns seen through the paired even/odd channel
  task automatic t_pins;
    logic [7:0] p;
    logic [7:0] l;
    bus(1'b1, PAGE_MUX, ADDR_PAIR_CFG, 8'h08);
    bus(1'b1, PAGE_MUX, ADDR_CHAN_SEL, 8'hf6);
    bus(1'b0, PAGE_MUX, ADDR_CHAN_SEL, 8'h00);
    chk("chan", 8'h06, sfr_rdata_out);
    for (int i = 0; i < 16; i++)
    begin
      p = {i[3:0], ~i[3:0]};
      l = 8'h5a ^ {2{i[3:0]}};
      levels <= l;
      bus(1'b1, PAGE_PIN_SELECT, ADDR_PIN_SELECT, p);
      chk("pins", p, pin_connect_out);
      chk("even", {7'h0, |(p & l & 8'h55)}, pos_lvl);
      chk("odd", {7'h0, |(p & l & 8'haa)}, neg_lvl);
      chk("active", {6'h0, |(p & 8'h55), |(p & 8'haa)},
        {6'h0, even_input_active_out, odd_input_active_out});
      bus(1'b0, PAGE_PIN_SELECT, ADDR_PIN_SELECT, 8'h00);
      chk("pin reg", p, sfr_rdata_out);
    end
    bus(1'b0, PAGE_MUX, 8'hbc, 8'h00);
    chk("unmapped", 8'h00, sfr_rdata_out);
  endtask : t_pins
  task automatic end_sim;
    if (err_total == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  // second reset comes with pins 0xf0 and pairing bit 3 set
  initial
  begin
    t_reset();
    t_table();
    t_pins();
    t_reset();
    end_sim();
  end
endmodule : test_adc_input_mux_control
`default_nettype wire
